// ---- adc_cfg_pkg.sv ----
// Functional notes
// R1: 3-bit ratio code, 32 doubling to 4096
// R2: ratio code comes up as 011 (256)
// R3: unimplemented bits always read back zero
// R4: low byte of word a is trim
// R5: six soft reset bits hold channels
// R6: six shutdown bits stop their channels
// R7: reference select picks outside or internal reference
// R8: clock select picks outside clock or crystal
// R9: writes to unimplemented bits are dropped
package adc_cfg_pkg;

  // bus shape
  localparam int DATA_W = 32;
  localparam int WORD_W = 24;
  localparam int WORD_BYTES = 4;
  localparam int LANES = 3;

  // printed register indexes, byte address is four times the index
  localparam logic [7:0] IDX_WORD_A = 8'h0d;
  localparam logic [7:0] IDX_WORD_B = 8'h0f;
  localparam int ADDR_WORD_A = 32'(IDX_WORD_A) * WORD_BYTES;
  localparam int ADDR_WORD_B = 32'(IDX_WORD_B) * WORD_BYTES;

  // field layout of word a
  localparam int OSR_LSB = 13;
  localparam int OSR_W = 3;
  localparam int TRIM_LSB = 0;
  localparam int TRIM_W = 8;

  // field layout of word b
  localparam int CHAN_N = 6;
  localparam int SRST_LSB = 16;
  localparam int SHDN_LSB = 8;
  localparam int REFSEL_BIT = 7;
  localparam int CLKSEL_BIT = 6;

  // reset values and writable masks
  localparam logic [OSR_W-1:0] OSR_RST = 3'h3;
  localparam logic [TRIM_W-1:0] TRIM_RST = 8'h50;
  localparam logic [WORD_W-1:0] WORD_A_RST = 24'h006050;
  localparam logic [WORD_W-1:0] WORD_A_MASK = 24'h00e0ff;
  localparam logic [WORD_W-1:0] WORD_B_RST = 24'h000040;
  localparam logic [WORD_W-1:0] WORD_B_MASK = 24'h3f3fc0;

  // ratio encoding: smallest ratio shifted left by the code
  localparam int RATIO_W = 13;
  localparam logic [RATIO_W-1:0] RATIO_MIN = 13'h0020;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_A = 2'b01,
    SEL_B = 2'b10
  } word_sel_t;

  typedef struct packed {
    logic [CHAN_N-1:0] soft_reset;
    logic [CHAN_N-1:0] shutdown;
    logic outside_ref;
    logic internal_ref_en;
    logic outside_clock;
    logic crystal_en;
  } chan_ctrl_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic [LANES-1:0] strb;
  } word_write_t;

  // code to oversampling ratio
  function automatic logic [RATIO_W-1:0] ratio_of_code(input logic [OSR_W-1:0] code);
    ratio_of_code = RATIO_MIN << code;
  endfunction

  // merge a write into a word honouring byte lanes and writable bits
  function automatic logic [WORD_W-1:0] apply_write(input logic [WORD_W-1:0] old_word,
                                                     input word_write_t wr,
                                                     input logic [WORD_W-1:0] mask);
    logic [WORD_W-1:0] merged;
    merged = old_word;
    for (int i = 0; i < LANES; i++) begin
      if (wr.strb[i]) begin
        merged[i*8 +: 8] = wr.data[i*8 +: 8];
      end
    end
    apply_write = merged & mask;
  endfunction

  localparam logic [RATIO_W-1:0] RATIO_RST = ratio_of_code(OSR_RST);

endpackage

// ---- config_word.sv ----
module config_word
  import adc_cfg_pkg::*;
#(
  parameter logic [WORD_W-1:0] RESET_VALUE = '0,
  parameter logic [WORD_W-1:0] WRITE_MASK = '1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire word_write_t wr_in,
  output logic [WORD_W-1:0] word_out
);

  typedef struct packed {
    logic [WORD_W-1:0] word;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // masked store: bits outside the mask never leave zero
  always_comb begin
    state_next = state_reg;
    if (wr_en_in) begin
      state_next.word = apply_write(state_reg.word, wr_in, WRITE_MASK); // R9
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= '{word: RESET_VALUE};
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  assign word_out = state_reg.word;

endmodule

// ---- config_decode.sv ----
module config_decode
  import adc_cfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [WORD_W-1:0] word_a_in,
  input wire logic [WORD_W-1:0] word_b_in,
  output logic [RATIO_W-1:0] ratio_out,
  output chan_ctrl_t chan_out
);

  typedef struct packed {
    logic [RATIO_W-1:0] ratio;
    chan_ctrl_t chan;
  } state_t;

  localparam state_t STATE_RST = '{
    ratio: RATIO_RST,
    chan: '{soft_reset: '0, shutdown: '0, outside_ref: 1'b0, internal_ref_en: 1'b1,
            outside_clock: 1'b1, crystal_en: 1'b0}
  };

  state_t state_reg;
  state_t state_next;

  // registered decode so every control line leaves a flip-flop
  always_comb begin
    state_next = state_reg;
    state_next.ratio = ratio_of_code(word_a_in[OSR_LSB +: OSR_W]); // R1
    state_next.chan.soft_reset = word_b_in[SRST_LSB +: CHAN_N]; // R5
    state_next.chan.shutdown = word_b_in[SHDN_LSB +: CHAN_N]; // R6
    state_next.chan.outside_ref = word_b_in[REFSEL_BIT]; // R7
    state_next.chan.internal_ref_en = ~word_b_in[REFSEL_BIT]; // R7
    state_next.chan.outside_clock = word_b_in[CLKSEL_BIT]; // R8
    state_next.chan.crystal_en = ~word_b_in[CLKSEL_BIT]; // R8
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= STATE_RST;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  assign ratio_out = state_reg.ratio;
  assign chan_out = state_reg.chan;

endmodule

// ---- adc_config_registers.sv ----
module adc_config_registers
  import adc_cfg_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CLK_EN_IN,
  // write address channel
  input wire logic [ADDR_WIDTH-1:0] S_AXI_AWADDR_IN,
  input wire logic [2:0] S_AXI_AWPROT_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  // write data channel
  input wire logic [DATA_W-1:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  // write response channel
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  // read address channel
  input wire logic [ADDR_WIDTH-1:0] S_AXI_ARADDR_IN,
  input wire logic [2:0] S_AXI_ARPROT_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  // read data channel
  output logic [DATA_W-1:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // converter controls
  output logic [OSR_W-1:0] OVERSAMPLE_RATIO_SEL_OUT,
  output logic [RATIO_W-1:0] OVERSAMPLE_RATIO_OUT,
  output logic [TRIM_W-1:0] REF_TEMPCO_TRIM_OUT,
  output logic [CHAN_N-1:0] CHAN_SOFT_RESET_OUT,
  output logic [CHAN_N-1:0] CHAN_SHUTDOWN_OUT,
  output logic OUTSIDE_REF_SELECT_OUT,
  output logic INTERNAL_REF_ENABLE_OUT,
  output logic OUTSIDE_CLOCK_SELECT_OUT,
  output logic CRYSTAL_OSC_ENABLE_OUT
);

  // the highest register byte address must be reachable
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_addr_width
    $error("ADDR_WIDTH must lie between 8 and 32");
  end

  // write side waits in collect until both halves are held, then answers
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_RESP = 2'b01
  } write_state_t;

  // read side: one read at a time, data held until taken
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } read_state_t;

  typedef struct packed {
    // write side
    write_state_t wst;
    logic aw_have;
    logic w_have;
    logic [ADDR_WIDTH-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    // read side
    read_state_t rst;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } state_t;

  // readies start high so the first request can be taken at once
  localparam state_t STATE_RST = '{
    // write side idle, both halves free
    wst: WR_COLLECT,
    aw_have: 1'b0,
    w_have: 1'b0,
    awaddr: '0,
    wdata: '0,
    wstrb: '0,
    awready: 1'b1,
    wready: 1'b1,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    // read side idle
    rst: RD_IDLE,
    arready: 1'b1,
    rvalid: 1'b0,
    rdata: '0,
    rresp: RESP_OKAY
  };

  state_t state_reg;
  state_t state_next;

  // storage and decode wires
  logic [WORD_W-1:0] word_a;
  logic [WORD_W-1:0] word_b;
  logic wr_a;
  logic wr_b;
  word_write_t wr_cmd;

  // decoded controls from the pipeline stage
  logic [RATIO_W-1:0] ratio;
  chan_ctrl_t chan;

  // full word decode; any other address or sub-word offset is unmapped
  // decoding the full byte address keeps aliases from answering as registers
  function automatic word_sel_t word_sel(input logic [ADDR_WIDTH-1:0] addr);
    if (32'(addr) == ADDR_WORD_A) begin
      word_sel = SEL_A;
    end else if (32'(addr) == ADDR_WORD_B) begin
      word_sel = SEL_B;
    end else begin
      word_sel = SEL_NONE;
    end
  endfunction

  // read image of a word: stored bits only, upper byte of the bus word zero
  function automatic logic [DATA_W-1:0] read_image(input word_sel_t sel,
                                                    input logic [WORD_W-1:0] a,
                                                    input logic [WORD_W-1:0] b);
    case (sel)
      SEL_A: read_image = {8'h00, a & WORD_A_MASK};
      SEL_B: read_image = {8'h00, b & WORD_B_MASK};
      default: read_image = '0;
    endcase
  endfunction

  // write channel: address and data may arrive in either order
  always_comb begin
    word_sel_t wsel;
    word_sel_t rsel;
    wsel = SEL_NONE;
    rsel = SEL_NONE;
    state_next = state_reg;
    wr_a = 1'b0;
    wr_b = 1'b0;
    wr_cmd = '{data: state_reg.wdata[WORD_W-1:0], strb: state_reg.wstrb[LANES-1:0]};

    case (state_reg.wst)
      WR_COLLECT: begin
        // address half: held here until the data half arrives
        if (S_AXI_AWVALID_IN && state_reg.awready) begin
          state_next.aw_have = 1'b1;
          state_next.awaddr = S_AXI_AWADDR_IN;
          state_next.awready = 1'b0;
        end
        // data half: may come before, with or after the address
        if (S_AXI_WVALID_IN && state_reg.wready) begin
          state_next.w_have = 1'b1;
          state_next.wdata = S_AXI_WDATA_IN;
          state_next.wstrb = S_AXI_WSTRB_IN;
          state_next.wready = 1'b0;
        end
        // both halves present: commit in this very edge, answer next cycle
        if (state_next.aw_have && state_next.w_have) begin
          wsel = word_sel(state_next.awaddr);
          wr_cmd = '{data: state_next.wdata[WORD_W-1:0], strb: state_next.wstrb[LANES-1:0]};
          wr_a = (wsel == SEL_A) && CLK_EN_IN;
          wr_b = (wsel == SEL_B) && CLK_EN_IN;
          state_next.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
          state_next.bvalid = 1'b1;
          state_next.aw_have = 1'b0;
          state_next.w_have = 1'b0;
          state_next.wst = WR_RESP;
        end
      end
      WR_RESP: begin
        // readies come back only once the response is taken
        if (S_AXI_BREADY_IN) begin
          state_next.bvalid = 1'b0;
          state_next.awready = 1'b1;
          state_next.wready = 1'b1;
          state_next.wst = WR_COLLECT;
        end
      end
      default: begin
        state_next.wst = WR_COLLECT;
        state_next.bvalid = 1'b0;
        state_next.awready = 1'b1;
        state_next.wready = 1'b1;
      end
    endcase

    // read channel: one read in flight, data captured at the address edge
    case (state_reg.rst)
      RD_IDLE: begin
        // a write committed at this same edge is not yet seen here
        if (S_AXI_ARVALID_IN && state_reg.arready) begin
          rsel = word_sel(S_AXI_ARADDR_IN);
          state_next.rdata = read_image(rsel, word_a, word_b); // R3
          state_next.rresp = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
          state_next.rvalid = 1'b1;
          state_next.arready = 1'b0;
          state_next.rst = RD_DATA;
        end
      end
      RD_DATA: begin
        if (S_AXI_RREADY_IN) begin
          state_next.rvalid = 1'b0;
          state_next.arready = 1'b1;
          state_next.rst = RD_IDLE;
        end
      end
      default: begin
        state_next.rst = RD_IDLE;
        state_next.rvalid = 1'b0;
        state_next.arready = 1'b1;
      end
    endcase
  end

  // bus state; a low clock enable freezes everything
  // limitation: the readies are flops and keep their level while the enable is low,
  // so a master must not offer a request then, or it would be lost; gating the
  // readies would have put logic between the flops and the outputs
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      state_reg <= STATE_RST;
    end else if (CLK_EN_IN) begin
      state_reg <= state_next;
    end
  end

  // first word: ratio code and reference trim, defaults 011 and 8'h50
  config_word #(
    .RESET_VALUE(WORD_A_RST), // R2
    .WRITE_MASK(WORD_A_MASK) // R9
  ) u_word_a (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .ce_in(CLK_EN_IN),
    .wr_en_in(wr_a),
    .wr_in(wr_cmd),
    .word_out(word_a)
  );

  // second word: per-channel reset and shutdown, reference and clock source
  config_word #(
    .RESET_VALUE(WORD_B_RST), // R8
    .WRITE_MASK(WORD_B_MASK) // R9
  ) u_word_b (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .ce_in(CLK_EN_IN),
    .wr_en_in(wr_b),
    .wr_in(wr_cmd),
    .word_out(word_b)
  );

  // decoded controls lag the stored words by one cycle
  config_decode u_decode (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .ce_in(CLK_EN_IN),
    .word_a_in(word_a),
    .word_b_in(word_b),
    .ratio_out(ratio),
    .chan_out(chan)
  );

  // bus outputs straight from the state flops
  assign S_AXI_AWREADY_OUT = state_reg.awready;
  assign S_AXI_WREADY_OUT = state_reg.wready;
  assign S_AXI_BVALID_OUT = state_reg.bvalid;
  assign S_AXI_BRESP_OUT = state_reg.bresp;

  // read channel outputs
  assign S_AXI_ARREADY_OUT = state_reg.arready;
  assign S_AXI_RVALID_OUT = state_reg.rvalid;
  assign S_AXI_RDATA_OUT = state_reg.rdata;
  assign S_AXI_RRESP_OUT = state_reg.rresp;

  // ratio code and trim go out as they sit in the word flops, the ratio comes from the decode flops
  assign OVERSAMPLE_RATIO_SEL_OUT = word_a[OSR_LSB +: OSR_W]; // R1
  assign REF_TEMPCO_TRIM_OUT = word_a[TRIM_LSB +: TRIM_W]; // R4
  assign OVERSAMPLE_RATIO_OUT = ratio; // R1

  // channel and source controls from the decode flops
  assign CHAN_SOFT_RESET_OUT = chan.soft_reset; // R5
  assign CHAN_SHUTDOWN_OUT = chan.shutdown; // R6
  assign OUTSIDE_REF_SELECT_OUT = chan.outside_ref; // R7
  assign INTERNAL_REF_ENABLE_OUT = chan.internal_ref_en; // R7
  assign OUTSIDE_CLOCK_SELECT_OUT = chan.outside_clock; // R8
  assign CRYSTAL_OSC_ENABLE_OUT = chan.crystal_en; // R8

  // protection bits carry no meaning for these registers
  logic prot_unused;
  assign prot_unused = ^{S_AXI_AWPROT_IN, S_AXI_ARPROT_IN, word_a[WORD_W-1:OSR_LSB+OSR_W]};

endmodule

// ---- adc_config_registers_props.sv ----
module adc_config_registers_props
  import adc_cfg_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CLK_EN_IN,
  input wire logic [ADDR_WIDTH-1:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic [DATA_W-1:0] S_AXI_RDATA_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic [1:0] S_AXI_BRESP_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic [OSR_W-1:0] OVERSAMPLE_RATIO_SEL_OUT,
  input wire logic [RATIO_W-1:0] OVERSAMPLE_RATIO_OUT,
  input wire logic [TRIM_W-1:0] REF_TEMPCO_TRIM_OUT,
  input wire logic [CHAN_N-1:0] CHAN_SOFT_RESET_OUT,
  input wire logic [CHAN_N-1:0] CHAN_SHUTDOWN_OUT,
  input wire logic OUTSIDE_REF_SELECT_OUT,
  input wire logic INTERNAL_REF_ENABLE_OUT,
  input wire logic OUTSIDE_CLOCK_SELECT_OUT,
  input wire logic CRYSTAL_OSC_ENABLE_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic [ADDR_WIDTH-1:0] rd_addr_reg;
  // keep the read address so the returned word can be judged by its register
  always_ff @(posedge REF_CLK_IN) begin
    if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && CLK_EN_IN) begin
      rd_addr_reg <= S_AXI_ARADDR_IN;
    end
  end
  property p_ratio;
    $past(CLK_EN_IN) |-> OVERSAMPLE_RATIO_OUT == (13'h0020 << $past(OVERSAMPLE_RATIO_SEL_OUT));
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio does not follow code");
  property p_ratio_rst;
    $fell(SYS_RST_IN) |-> OVERSAMPLE_RATIO_SEL_OUT == 3'h3 && OVERSAMPLE_RATIO_OUT == 13'h0100;
  endproperty
  a_ratio_rst: assert property (p_ratio_rst) else $error("ratio not 256 after reset");
  property p_zero_b;
    S_AXI_RVALID_OUT && rd_addr_reg == ADDR_WIDTH'(ADDR_WORD_B) |->
      (S_AXI_RDATA_OUT & 32'hffc0c03f) == 32'h0;
  endproperty
  a_zero_b: assert property (p_zero_b) else $error("word b spare bits set");
  property p_zero_a;
    S_AXI_RVALID_OUT && rd_addr_reg == ADDR_WIDTH'(ADDR_WORD_A) |->
      (S_AXI_RDATA_OUT & 32'hffff1f00) == 32'h0;
  endproperty
  a_zero_a: assert property (p_zero_a) else $error("word a spare bits set");
  property p_trim;
    $changed(REF_TEMPCO_TRIM_OUT) |-> $rose(S_AXI_BVALID_OUT) && S_AXI_BRESP_OUT == 2'h0;
  endproperty
  a_trim: assert property (p_trim) else $error("trim moved without a write");
  property p_srst;
    $changed(CHAN_SOFT_RESET_OUT) |-> $past(S_AXI_BVALID_OUT) && $past(S_AXI_BRESP_OUT) == 2'h0;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset moved without a write");
  property p_shdn;
    !$past(S_AXI_BVALID_OUT) |-> $stable(CHAN_SHUTDOWN_OUT);
  endproperty
  a_shdn: assert property (p_shdn) else $error("shutdown moved without a write");
  // the pair must disagree, and the select may only move right after a write answer
  property p_ref;
    OUTSIDE_REF_SELECT_OUT != INTERNAL_REF_ENABLE_OUT &&
      (!$changed(OUTSIDE_REF_SELECT_OUT) || $past(S_AXI_BVALID_OUT));
  endproperty
  a_ref: assert property (p_ref) else $error("reference controls inconsistent");
  property p_clk;
    OUTSIDE_CLOCK_SELECT_OUT != CRYSTAL_OSC_ENABLE_OUT &&
      (!$changed(OUTSIDE_CLOCK_SELECT_OUT) || $past(S_AXI_BVALID_OUT));
  endproperty
  a_clk: assert property (p_clk) else $error("clock controls inconsistent");
  c_unmapped: cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == 2'h2);
  c_read_b: cover property (S_AXI_RVALID_OUT && rd_addr_reg == ADDR_WIDTH'(ADDR_WORD_B));
  c_shdn: cover property ($changed(CHAN_SHUTDOWN_OUT));
endmodule

// ---- axil_host_model.sv ----
module axil_host_model (
  input wire logic clk_in,
  output logic [7:0] aw_addr_out,
  output logic aw_valid_out,
  input wire logic aw_ready_in,
  output logic [31:0] w_data_out,
  output logic [3:0] w_strb_out,
  output logic w_valid_out,
  input wire logic w_ready_in,
  input wire logic [1:0] b_resp_in,
  input wire logic b_valid_in,
  output logic b_ready_out,
  output logic [7:0] ar_addr_out,
  output logic ar_valid_out,
  input wire logic ar_ready_in,
  input wire logic [31:0] r_data_in,
  input wire logic [1:0] r_resp_in,
  input wire logic r_valid_in,
  output logic r_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hung;
  // idle bus at time zero
  initial begin
    {aw_addr_out, aw_valid_out, w_data_out, w_strb_out, w_valid_out} = '0;
    {b_ready_out, ar_addr_out, ar_valid_out, r_ready_out, hung} = '0;
  end
  // released address and data lines carry the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_in);
    aw_addr_out <= a;
    w_data_out <= d;
    w_strb_out <= s;
    aw_valid_out <= 1'b1;
    w_valid_out <= 1'b1;
    b_ready_out <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (aw_valid_out && aw_ready_in) begin
        aw_valid_out <= 1'b0;
        aw_addr_out <= ~a;
      end
      if (w_valid_out && w_ready_in) begin
        w_valid_out <= 1'b0;
        w_data_out <= ~d;
      end
    end while (!b_valid_in && n < 64);
    r = b_resp_in;
    hung = !b_valid_in;
    b_ready_out <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_in);
    ar_addr_out <= a;
    ar_valid_out <= 1'b1;
    r_ready_out <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (ar_valid_out && ar_ready_in) begin
        ar_valid_out <= 1'b0;
        ar_addr_out <= ~a;
      end
    end while (!r_valid_in && n < 64);
    d = r_data_in;
    r = r_resp_in;
    hung = !r_valid_in;
    r_ready_out <= 1'b0;
  endtask
endmodule

// ---- test_adc_config_registers.sv ----
module test_adc_config_registers
  import adc_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b1;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic [2:0] sel;
  logic [12:0] ratio;
  logic [7:0] trim;
  logic [5:0] srst, shdn;
  logic oref, iref, oclk, xtal;
  logic [31:0] sa = 32'h006050;
  logic [31:0] sb = 32'h000040;
  int fails = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  adc_config_registers adc_config_registers_i (
    .REF_CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(en),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWPROT_IN(3'h0), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_rdy), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARPROT_IN(3'h0), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(rr), .OVERSAMPLE_RATIO_SEL_OUT(sel), .OVERSAMPLE_RATIO_OUT(ratio),
    .REF_TEMPCO_TRIM_OUT(trim), .CHAN_SOFT_RESET_OUT(srst), .CHAN_SHUTDOWN_OUT(shdn),
    .OUTSIDE_REF_SELECT_OUT(oref), .INTERNAL_REF_ENABLE_OUT(iref),
    .OUTSIDE_CLOCK_SELECT_OUT(oclk), .CRYSTAL_OSC_ENABLE_OUT(xtal));
  axil_host_model axil_host_model_i (
    .clk_in(clk), .aw_addr_out(awaddr), .aw_valid_out(awv), .aw_ready_in(awr),
    .w_data_out(wdata), .w_strb_out(wstrb), .w_valid_out(wv), .w_ready_in(wr_rdy),
    .b_resp_in(bresp), .b_valid_in(bv), .b_ready_out(br), .ar_addr_out(araddr),
    .ar_valid_out(arv), .ar_ready_in(arr), .r_data_in(rdata), .r_resp_in(rresp),
    .r_valid_in(rv), .r_ready_out(rr));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize;
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // expected word: byte lanes 0..2 merged, then only writable bits kept
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    for (int i = 0; i < 3; i++) begin
      if (s[i]) begin
        o[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return o & m;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    axil_host_model_i.wr(a, d, s, r);
    chk("bus wait", 32'h0, 32'(axil_host_model_i.hung));
    if (axil_host_model_i.hung) summarize();
    chk("write resp", (a == 8'h34 || a == 8'h3c) ? 32'h0 : 32'h2, 32'(r));
    if (a == 8'h34) sa = merge(sa, d, s, 32'h00e0ff);
    if (a == 8'h3c) sb = merge(sb, d, s, 32'h3f3fc0);
  endtask
  // unmapped reads must answer zero with an error response
  task automatic rd(input logic [7:0] a);
    logic [31:0] d;
    logic [1:0] r;
    axil_host_model_i.rd(a, d, r);
    chk("bus wait", 32'h0, 32'(axil_host_model_i.hung));
    if (axil_host_model_i.hung) summarize();
    chk("read resp", (a == 8'h34 || a == 8'h3c) ? 32'h0 : 32'h2, 32'(r));
    chk("read data", a == 8'h34 ? sa : a == 8'h3c ? sb : 32'h0, d);
  endtask
  task automatic outs;
    @(negedge clk);
    chk("ratio code", 32'(sa[15:13]), 32'(sel));
    chk("ratio", 32'(13'h0020 << sa[15:13]), 32'(ratio));
    chk("trim", 32'(sa[7:0]), 32'(trim));
    chk("soft reset", 32'(sb[21:16]), 32'(srst));
    chk("shutdown", 32'(sb[13:8]), 32'(shdn));
    chk("reference", 32'({sb[7], ~sb[7]}), 32'({oref, iref}));
    chk("clock source", 32'({sb[6], ~sb[6]}), 32'({oclk, xtal}));
  endtask
  initial begin
    logic [31:0] d;
    void'($urandom(32'h20292a23));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    outs();
    rd(8'h34);
    rd(8'h3c);
    // every ratio code, with spare bits 12:8 written high
    for (int c = 0; c < 8; c++) begin
      d = {16'($urandom), 3'(c), 5'h1f, 8'($urandom)};
      wr(8'h34, d, 4'hf);
      rd(8'h34);
      outs();
    end
    // all ones then all zeros into word b
    for (int k = 0; k < 2; k++) begin
      wr(8'h3c, k ? 32'h0 : 32'hffffffff, 4'hf);
      rd(8'h3c);
      outs();
    end
    repeat (24) begin
      d = $urandom;
      wr($urandom_range(1) ? 8'h3c : 8'h34, d, 4'($urandom));
      rd(8'h3c);
      rd(8'h34);
      outs();
    end
    // unmapped and misaligned places leave both words alone
    wr(8'h38, 32'hffffffff, 4'hf);
    wr(8'h35, 32'hffffffff, 4'hf);
    rd(8'h38);
    rd(8'hfc);
    rd(8'h34);
    rd(8'h3c);
    outs();
    summarize();
  end
endmodule
bind adc_config_registers adc_config_registers_props #(.ADDR_WIDTH(ADDR_WIDTH))
  adc_config_registers_props_i (
  .REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .CLK_EN_IN(CLK_EN_IN),
  .S_AXI_ARADDR_IN(S_AXI_ARADDR_IN), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
  .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
  .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_BRESP_OUT(S_AXI_BRESP_OUT),
  .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .OVERSAMPLE_RATIO_SEL_OUT(OVERSAMPLE_RATIO_SEL_OUT),
  .OVERSAMPLE_RATIO_OUT(OVERSAMPLE_RATIO_OUT), .REF_TEMPCO_TRIM_OUT(REF_TEMPCO_TRIM_OUT),
  .CHAN_SOFT_RESET_OUT(CHAN_SOFT_RESET_OUT), .CHAN_SHUTDOWN_OUT(CHAN_SHUTDOWN_OUT),
  .OUTSIDE_REF_SELECT_OUT(OUTSIDE_REF_SELECT_OUT),
  .INTERNAL_REF_ENABLE_OUT(INTERNAL_REF_ENABLE_OUT),
  .OUTSIDE_CLOCK_SELECT_OUT(OUTSIDE_CLOCK_SELECT_OUT),
  .CRYSTAL_OSC_ENABLE_OUT(CRYSTAL_OSC_ENABLE_OUT));
